// ===== rtl/rwps_defs.svh
// Constants for the standby power-up sequencer
`ifndef RWPS_DEFS_SVH
`define RWPS_DEFS_SVH
`define RWPS_CLK_PERIOD_NS 40
`define RWPS_STRAP_HOLD_NS 400
`define RWPS_STRAP_W 4
`define RWPS_STRAP_APL_BIT 0
`define RWPS_STRAP_RST 4'h0
`define RWPS_SYNC_STAGES 2
`define RWPS_HOLD_CNT_W 4
`define RWPS_HOLD_CNT_RST 4'h0
`define RWPS_HOLD_CNT_STEP 4'h1
`endif

// ===== rtl/rwps_pkg.sv
// Types for the standby power-up sequencer
package rwps_pkg;
  typedef enum logic [1:0] {
    RWPS_MECH_OFF,
    RWPS_SOFT_OFF,
    RWPS_FULL_ON
  } rwps_state_e;
endpackage : rwps_pkg

// ===== rtl/rwps_reset_sync.sv
// Reset synchroniser: asynchronous assert, synchronous release
module rwps_reset_sync (
  input wire logic clk, // Clock
  input wire logic async_n, // Asynchronous active-low input
  output logic sync_n // Synchronised active-low output
);
  logic meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge async_n) begin
    if (!async_n) begin
      meta_q <= 1'b0;
      sync_n <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      sync_n <= meta_q;
    end
  end
endmodule : rwps_reset_sync

// ===== rtl/rwps_seq.sv
// Standby power-up and RTC-well reset sequencer
`include "rwps_defs.svh"
module rwps_seq (
  input wire logic core_clk, // 25 MHz always-on clock
  input wire logic rst, // Asynchronous active-high reset
  input wire logic rtc_battery_test_n, // Battery test, low = weak or missing battery
  input wire logic rtc_well_reset_n, // RTC-well reset, active low
  input wire logic standby_power_good_reset_n, // Standby power-good reset, active low
  input wire logic [`RWPS_STRAP_W-1:0] strap_pins, // Hard strap pins, bit 0 = after_power_loss_strap
  input wire logic wake_event, // Wake event pulse
  input wire logic apl_cfg_wr, // Write strobe for the stored power-loss setting
  input wire logic apl_cfg_wdata, // Value written: 1 = stay off after power loss
  output logic battery_ok, // Current battery-test level
  output logic first_power_up, // First power-up condition remembered
  output logic rtc_regs_in_reset, // RTC-well bits held at defaults
  output logic [`RWPS_STRAP_W-1:0] strap_captured, // Captured strap values
  output logic straps_valid, // Straps have been captured
  output logic apl_cfg, // Stored power-loss setting (RTC well)
  output logic soft_off_indicator_n, // Low while in soft-off
  output rwps_pkg::rwps_state_e power_state // Current power state
);
  import rwps_pkg::*;

  localparam int unsigned HOLD_CYC =
    (`RWPS_STRAP_HOLD_NS + `RWPS_CLK_PERIOD_NS - 1) / `RWPS_CLK_PERIOD_NS;
  // Copy point in cycles after the release is seen; half the hold leaves margin
  localparam int unsigned SAMPLE_CYC = HOLD_CYC / 2;
  localparam logic [`RWPS_HOLD_CNT_W-1:0] SAMPLE_AT = SAMPLE_CYC[`RWPS_HOLD_CNT_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Reset synchronisers
  // Each input asserts at once but releases on a clock edge, so no flop sees a
  // release close to its clock; the cost is two cycles of release delay.
  logic rtc_rst_sync_n;
  logic bat_sync_n;
  logic spg_sync_n;
  logic rtc_any_n;

  // Either low input clears the RTC well
  assign rtc_any_n = rtc_well_reset_n & rtc_battery_test_n;

  rwps_reset_sync u_sync_rtc (
    .clk(core_clk),
    .async_n(rtc_any_n),
    .sync_n(rtc_rst_sync_n)
  );
  rwps_reset_sync u_sync_bat (
    .clk(core_clk),
    .async_n(rtc_battery_test_n),
    .sync_n(bat_sync_n)
  );
  rwps_reset_sync u_sync_spg (
    .clk(core_clk),
    .async_n(standby_power_good_reset_n),
    .sync_n(spg_sync_n)
  );

  // Battery level is exposed as synchronised, so software sees no metastability
  assign battery_ok = bat_sync_n;
  assign rtc_regs_in_reset = ~rtc_rst_sync_n;

  //////////////////////////////////////////////////////////////////////////////
  // RTC-well bits: leave reset only once both the RTC-well reset and battery-test inputs are high
  // These flops ignore rst on purpose: a standby loss must not wipe what the
  // RTC well keeps, only the battery-test or RTC-well reset input may do that.
  logic bat_was_low_q;

  // Stored setting survives standby loss, cleared only by an RTC-well reset
  always_ff @(posedge core_clk or negedge rtc_rst_sync_n) begin
    if (!rtc_rst_sync_n) begin
      apl_cfg <= 1'b0;
    end else if (apl_cfg_wr) begin
      apl_cfg <= apl_cfg_wdata;
    end
  end

  // First power-up flag set by RTC-well defaults, cleared once fully on,
  // so only the power-up after an RTC-well clear is steered by the strap
  always_ff @(posedge core_clk or negedge rtc_rst_sync_n) begin
    if (!rtc_rst_sync_n) begin
      bat_was_low_q <= 1'b1;
    end else if (power_state == RWPS_FULL_ON) begin
      bat_was_low_q <= 1'b0;
    end
  end

  // Without a good battery every power-up is treated as the first
  assign first_power_up = bat_was_low_q | ~bat_sync_n;

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture after standby-power-good release
  // The pins are copied a fixed count after the synchronised release is seen, so
  // the copy lands inside the platform's hold window whatever the pin timing.
  // Limitation: synchroniser, edge detect and count together must stay shorter
  // than the hold window, or the copy may catch pins that have already moved.
  logic spg_q;
  logic [`RWPS_HOLD_CNT_W-1:0] hold_cnt_q;
  logic capturing_q;
  logic spg_rise;
  logic sample_now;

  // Edge detect on the synchronised level, never on the first stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      spg_q <= 1'b0;
    end else begin
      spg_q <= spg_sync_n;
    end
  end

  // Reset value of the edge detect matches the asserted pin, so no false edge
  assign spg_rise = spg_sync_n & ~spg_q;

  // Single cycle in which the pins are copied; a new assertion cancels it
  assign sample_now = spg_sync_n & capturing_q & (hold_cnt_q == SAMPLE_AT);

  // Capture window opens on the release and closes after the copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      capturing_q <= 1'b0;
    end else if (!spg_sync_n) begin
      capturing_q <= 1'b0;
    end else if (spg_rise) begin
      capturing_q <= 1'b1;
    end else if (sample_now) begin
      capturing_q <= 1'b0;
    end
  end

  // Cycles since the release was seen, parked once the window closes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_cnt_q <= `RWPS_HOLD_CNT_RST;
    end else if (!spg_sync_n || spg_rise) begin
      hold_cnt_q <= `RWPS_HOLD_CNT_RST;
    end else if (capturing_q) begin
      hold_cnt_q <= hold_cnt_q + `RWPS_HOLD_CNT_STEP;
    end
  end

  // Captured values kept until the next copy, so the power-up can use them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_captured <= `RWPS_STRAP_RST;
    end else if (sample_now) begin
      strap_captured <= strap_pins;
    end
  end

  // Valid flag drops with the standby reset and rises with the copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      straps_valid <= 1'b0;
    end else if (!spg_sync_n) begin
      straps_valid <= 1'b0;
    end else if (sample_now) begin
      straps_valid <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-state controller: no sleep states exist
  // A standby reset always returns to mechanical-off, whatever the state, so a
  // brown-out in fully-on never leaves the indicator showing a stale state.
  // Limitation: a wake event seen in mechanical-off is not remembered.
  logic stay_off;

  // Strap decides on first power-up, stored setting otherwise
  assign stay_off = first_power_up ? strap_captured[`RWPS_STRAP_APL_BIT] : apl_cfg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_state <= RWPS_MECH_OFF;
    end else if (!spg_sync_n) begin
      power_state <= RWPS_MECH_OFF;
    end else begin
      case (power_state)
        RWPS_MECH_OFF: begin
          if (straps_valid) begin
            power_state <= RWPS_SOFT_OFF;
          end
        end
        RWPS_SOFT_OFF: begin
          if (!stay_off || wake_event) begin
            power_state <= RWPS_FULL_ON;
          end
        end
        RWPS_FULL_ON: begin
          power_state <= RWPS_FULL_ON;
        end
        default: begin
          power_state <= RWPS_MECH_OFF;
        end
      endcase
    end
  end

  // Indicator low only in soft-off; high otherwise
  // Registered so the pin never glitches while the state changes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      soft_off_indicator_n <= 1'b1;
    end else begin
      soft_off_indicator_n <= ~(power_state == RWPS_SOFT_OFF);
    end
  end
endmodule : rwps_seq

// ===== tb/rwps_board.sv
// Platform board model driving the reset and strap pins
`include "rwps_defs.svh"
module rwps_board (
  input wire logic core_clk, // Clock
  output logic rtc_battery_test_n, // Battery test
  output logic rtc_well_reset_n, // RTC-well reset
  output logic standby_power_good_reset_n, // Standby reset
  output logic [`RWPS_STRAP_W-1:0] strap_pins // Straps
);
  timeunit 1ns;
  timeprecision 1ns;
  // Millisecond waits scaled down to cycles to keep the run short
  localparam int CLR_CYC = 9;
  localparam int STBY_CYC = 10;
  localparam int HOLD_CYC = `RWPS_STRAP_HOLD_NS / `RWPS_CLK_PERIOD_NS;
  // Board starts with every reset asserted
  initial begin
    {rtc_battery_test_n, rtc_well_reset_n, standby_power_good_reset_n} = 3'h0;
    strap_pins = 4'h0;
  end
  // Release the RTC-well reset, and drive battery test to bat, only once the well could clear
  task automatic rtc_up(input logic bat);
    repeat (CLR_CYC) @(posedge core_clk);
    #1 rtc_well_reset_n = 1'h1;
    rtc_battery_test_n = bat;
  endtask : rtc_up
  task automatic rtc_down;
    @(posedge core_clk);
    #1 {rtc_battery_test_n, rtc_well_reset_n} = 2'h0;
  endtask : rtc_down
  // Straps stand for the hold time only, then float (shown inverted)
  task automatic stby_up(input logic [`RWPS_STRAP_W-1:0] s);
    strap_pins = s;
    repeat (STBY_CYC) @(posedge core_clk);
    #1 standby_power_good_reset_n = 1'h1;
    repeat (HOLD_CYC) @(posedge core_clk);
    #1 strap_pins = ~s;
  endtask : stby_up
  task automatic stby_down;
    @(posedge core_clk);
    #1 standby_power_good_reset_n = 1'h0;
  endtask : stby_down
endmodule : rwps_board

// ===== tb/rwps_seq_sva.sv
// Assertion checker for the standby power-up sequencer
`include "rwps_defs.svh"
module rwps_seq_chk (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic rtc_battery_test_n, // In
  input wire logic rtc_well_reset_n, // In
  input wire logic standby_power_good_reset_n, // In
  input wire logic [`RWPS_STRAP_W-1:0] strap_pins, // In
  input wire logic wake_event, // In
  input wire logic battery_ok, // Out
  input wire logic first_power_up, // Out
  input wire logic rtc_regs_in_reset, // Out
  input wire logic [`RWPS_STRAP_W-1:0] strap_captured, // Out
  input wire logic straps_valid, // Out
  input wire logic apl_cfg, // Out
  input wire logic soft_off_indicator_n, // Out
  input wire rwps_pkg::rwps_state_e power_state // Out
);
  timeunit 1ns;
  timeprecision 1ns;
  import rwps_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Power-loss choice: strap on a first power-up, stored bit otherwise
  logic stay;
  assign stay = first_power_up ? strap_captured[0] : apl_cfg;
  sequence s_cap;
    $rose(straps_valid);
  endsequence
  property p_def;
    !rtc_well_reset_n || !rtc_battery_test_n |=> rtc_regs_in_reset && !apl_cfg;
  endproperty
  a_def: assert property (p_def) else $error("RTC bits not at defaults");
  property p_bat;
    !rtc_battery_test_n |=> !battery_ok;
  endproperty
  a_bat: assert property (p_bat) else $error("battery level wrong");
  property p_first;
    !rtc_battery_test_n |=> first_power_up;
  endproperty
  a_first: assert property (p_first) else $error("first power-up lost");
  property p_strap;
    s_cap |-> strap_captured == $past(strap_pins, 3);
  endproperty
  a_strap: assert property (p_strap) else $error("strap capture wrong");
  property p_soft;
    s_cap |=> power_state == RWPS_SOFT_OFF ##1 !soft_off_indicator_n;
  endproperty
  a_soft: assert property (p_soft) else $error("soft-off not shown");
  property p_go;
    power_state == RWPS_SOFT_OFF && standby_power_good_reset_n && (!stay || wake_event) |=> power_state == RWPS_FULL_ON;
  endproperty
  a_go: assert property (p_go) else $error("no move to fully-on");
  property p_wait;
    power_state == RWPS_SOFT_OFF && standby_power_good_reset_n && stay && !wake_event |=> power_state == RWPS_SOFT_OFF;
  endproperty
  a_wait: assert property (p_wait) else $error("left soft-off early");
  property p_drop;
    !standby_power_good_reset_n |-> ##[1:2] power_state == RWPS_MECH_OFF && !straps_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("standby reset ignored");
endmodule : rwps_seq_chk

// ===== tb/test_rtc_well_standby_powerup_seq.sv
// Testbench for the standby power-up sequencer
`include "rwps_defs.svh"
module test_rtc_well_standby_powerup_seq;
  timeunit 1ns;
  timeprecision 1ns;
  import rwps_pkg::*;
  logic core_clk, rst, wake_event, apl_cfg_wr, apl_cfg_wdata, rtc_battery_test_n, rtc_well_reset_n, apl_m;
  logic standby_power_good_reset_n, battery_ok, first_power_up, rtc_regs_in_reset, straps_valid, apl_cfg;
  logic soft_off_indicator_n;
  logic [`RWPS_STRAP_W-1:0] strap_pins, strap_captured;
  rwps_state_e power_state;
  int num_errors = 0;
  int num_checks = 0;
  rwps_seq rwps_seq_inst (.core_clk, .rst, .rtc_battery_test_n, .rtc_well_reset_n, .standby_power_good_reset_n,
    .strap_pins, .wake_event, .apl_cfg_wr, .apl_cfg_wdata, .battery_ok, .first_power_up, .rtc_regs_in_reset,
    .strap_captured, .straps_valid, .apl_cfg, .soft_off_indicator_n, .power_state);
  rwps_board rwps_board_inst (.core_clk, .rtc_battery_test_n, .rtc_well_reset_n, .standby_power_good_reset_n,
    .strap_pins);
  ////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // Bounded wait, so a stuck state cannot hang the run
  task automatic wait_st(input rwps_state_e e);
    int i;
    for (i = 0; i < 40 && power_state !== e; i++) step(1);
    chk(4'(i == 40), 4'h0);
    if (i == 40) close_out;
  endtask : wait_st
  task automatic wr(input logic v);
    apl_cfg_wr = 1'h1;
    apl_cfg_wdata = v;
    step(1);
    apl_cfg_wr = 1'h0;
    step(1);
  endtask : wr
  // Where a power-up settles: strap on a first power-up, kept setting otherwise
  function automatic rwps_state_e exp_state(input logic first, input logic strap, input logic kept);
    return (first ? strap : kept) ? RWPS_SOFT_OFF : RWPS_FULL_ON;
  endfunction : exp_state
  // One power-up from mechanical-off with random straps
  task automatic pwr(input logic first);
    logic [3:0] s;
    rwps_state_e e;
    s = 4'($urandom);
    e = exp_state(first, s[`RWPS_STRAP_APL_BIT], apl_m);
    rwps_board_inst.stby_up(s);
    chk(4'(first_power_up), 4'(first));
    chk(strap_captured, s);
    wait_st(e);
    step(2);
    chk(4'(power_state), 4'(e));
    chk(4'(soft_off_indicator_n), 4'(e == RWPS_FULL_ON));
    wake_event = 1'h1;
    step(1);
    wake_event = 1'h0;
    wait_st(RWPS_FULL_ON);
    rwps_board_inst.stby_down;
    wait_st(RWPS_MECH_OFF);
    chk(4'(straps_valid), 4'h0);
  endtask : pwr
  initial begin
    void'($urandom(32'h2CF25AF8));
    {rst, wake_event, apl_cfg_wr, apl_cfg_wdata, apl_m} = 5'h10;
    step(8);
    rst = 1'h0;
    // No battery: writes refused and every power-up is a first one
    rwps_board_inst.rtc_up(0);
    wr(1);
    chk(4'(apl_cfg), 4'h0);
    chk(4'(battery_ok), 4'h0);
    repeat (3) pwr(1);
    // Battery fitted: one first power-up, then the kept setting decides
    rwps_board_inst.rtc_down;
    rwps_board_inst.rtc_up(1);
    step(4);
    chk(4'(battery_ok), 4'h1);
    chk(4'(rtc_regs_in_reset), 4'h0);
    pwr(1);
    for (int i = 0; i < 6; i++) begin
      apl_m = 1'($urandom);
      wr(apl_m);
      pwr(0);
      chk(4'(apl_cfg), 4'(apl_m));
    end
    rwps_board_inst.rtc_down;
    step(3);
    chk(4'(apl_cfg), 4'h0);
    chk(4'(rtc_regs_in_reset), 4'h1);
    close_out;
  end
endmodule : test_rtc_well_standby_powerup_seq
bind rwps_seq rwps_seq_chk rwps_seq_chk_inst (.core_clk, .rst, .rtc_battery_test_n, .rtc_well_reset_n,
  .standby_power_good_reset_n, .strap_pins, .wake_event, .battery_ok, .first_power_up, .rtc_regs_in_reset,
  .strap_captured, .straps_valid, .apl_cfg, .soft_off_indicator_n, .power_state);
